// ---- hw/tmx_pkg.sv ----
// Constants, register map and mode codes for the timer A/B block
// Operation
// - One-shot stop while counting: halt, reload counter, pin low, flag timer A.
// - Flag timer A on one-shot chosen after reset or from timer/event.
// - Flag timer A on PWM chosen after reset or from timer/event.
// - PWM stop halts counter; if pin high, drive low and flag timer A.
// - PWM stop with pin already low: pin unchanged, no timer A flag.
// - Timer B count read returns live count, or FFFF at reload moment.
// - Timer B count written while halted reads back the written value.
// - Measurement select change after start flags timer B.
// - First measurement edge after start loads capture, raises no flag.
package tmx_pkg;

    // -------------------------------------------------------------
    // Register byte offsets
    // -------------------------------------------------------------
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_A_COUNT = 8'h04;
    localparam logic [7:0] OFF_B_COUNT = 8'h08;
    localparam logic [7:0] OFF_B_CAPTURE = 8'h0C;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h10;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h14;

    // -------------------------------------------------------------
    // Control register field positions
    // -------------------------------------------------------------
    localparam int CTRL_A_START = 0;
    localparam int CTRL_B_START = 1;
    localparam int CTRL_A_MODE_LO = 4;
    localparam int CTRL_B_MODE_LO = 8;
    localparam int CTRL_B_MSEL = 12;

    // Interrupt status and mask bit positions
    localparam int IRQ_A_BIT = 0;
    localparam int IRQ_B_BIT = 1;

    // -------------------------------------------------------------
    // Mode codes
    // -------------------------------------------------------------
    localparam logic [1:0] A_MODE_TIMER = 2'h0;
    localparam logic [1:0] A_MODE_EVENT = 2'h1;
    localparam logic [1:0] A_MODE_ONESHOT = 2'h2;
    localparam logic [1:0] A_MODE_PWM = 2'h3;
    localparam logic [1:0] B_MODE_TIMER = 2'h0;
    localparam logic [1:0] B_MODE_EVENT = 2'h1;
    localparam logic [1:0] B_MODE_MEASURE = 2'h2;

    // -------------------------------------------------------------
    // Reset values and fixed figures
    // -------------------------------------------------------------
    localparam logic [15:0] CNT_RESET = 16'h0000;
    localparam logic [15:0] CNT_RELOAD_READ = 16'hFFFF;
    localparam logic [1:0] MASK_RESET = 2'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : tmx_pkg

// ---- hw/tmx_sync_edge.sv ----
// Two-stage synchroniser with rising and falling edge pulses
`timescale 1ns/1ps
`default_nettype none
module tmx_sync_edge (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic pin_in,
    output logic rise,
    output logic fall
);
    logic meta_ff;
    logic sync_ff;
    logic prev_ff;

    // -------------------------------------------------------------
    // Synchroniser; only sync_ff reads meta_ff
    // -------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
            prev_ff <= 1'b0;
        end
        else
        begin
            meta_ff <= pin_in;
            sync_ff <= meta_ff;
            prev_ff <= sync_ff;
        end
    end

    assign rise = sync_ff & ~prev_ff;
    assign fall = ~sync_ff & prev_ff;
endmodule // tmx_sync_edge
`default_nettype wire

// ---- hw/tmx_timer_top.sv ----
// Timer A (timer/event/one-shot/PWM) and timer B (timer/event/measure)
//
// Implementation choices: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`default_nettype none
module tmx_timer_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic a_event_in,
    input wire logic b_event_in,
    output logic timer_a_output_pin,
    output logic irq
);
    import tmx_pkg::*;

    // -------------------------------------------------------------
    // Declarations
    // -------------------------------------------------------------
    logic aw_held_ff;
    logic [7:0] aw_addr_ff;
    logic w_held_ff;
    logic [31:0] w_data_ff;
    logic [3:0] w_strb_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;
    logic a_start_ff;
    logic b_start_ff;
    logic [1:0] a_mode_ff;
    logic [1:0] b_mode_ff;
    logic b_msel_ff;
    logic a_mode_set_ff;
    logic [15:0] a_cnt_ff;
    logic [15:0] a_reload_ff;
    logic a_pin_ff;
    logic a_done_ff;
    logic [15:0] b_cnt_ff;
    logic [15:0] b_reload_ff;
    logic b_first_ff;
    logic [1:0] status_ff;
    logic [1:0] mask_ff;
    logic wr_fire;
    logic rd_fire;
    logic wr_mapped;
    logic rd_mapped;
    logic ctrl_wr;
    logic a_cnt_wr;
    logic b_cnt_wr;
    logic mask_wr;
    logic [31:0] ctrl_rd;
    logic [31:0] nxt_ctrl;
    logic [31:0] nxt_a_cnt;
    logic [31:0] nxt_b_cnt;
    logic [31:0] nxt_mask;
    logic nxt_a_start;
    logic nxt_b_start;
    logic [1:0] nxt_a_mode;
    logic nxt_b_msel;
    logic a_rise;
    logic b_rise;
    logic b_fall;
    logic a_start_rise;
    logic a_stop;
    logic b_start_rise;
    logic a_os_like;
    logic a_tick;
    logic a_zero;
    logic a_run;
    logic a_under;
    logic a_mode_evt;
    logic a_evt;
    logic b_meas;
    logic b_tick;
    logic b_zero;
    logic b_reload_now;
    logic b_edge;
    logic b_evt;
    logic [1:0] nxt_status;

    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0] strb);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
            begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // -------------------------------------------------------------
    // Input edge detection
    // -------------------------------------------------------------
    tmx_sync_edge u_a_edge (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin_in(a_event_in),
        .rise(a_rise),
        .fall()
    );

    tmx_sync_edge u_b_edge (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin_in(b_event_in),
        .rise(b_rise),
        .fall(b_fall)
    );

    // -------------------------------------------------------------
    // AXI4-Lite slave
    // -------------------------------------------------------------
    assign awready = ~aw_held_ff;
    assign wready = ~w_held_ff;
    assign arready = ~rvalid_ff;
    assign bvalid = bvalid_ff;
    assign bresp = bresp_ff;
    assign rvalid = rvalid_ff;
    assign rdata = rdata_ff;
    assign rresp = rresp_ff;

    // Address and data may arrive in either order; commit when both held
    assign wr_fire = aw_held_ff & w_held_ff & ~bvalid_ff;
    assign rd_fire = arvalid & ~rvalid_ff;

    assign wr_mapped = (aw_addr_ff == OFF_CTRL) ||
                       (aw_addr_ff == OFF_A_COUNT) ||
                       (aw_addr_ff == OFF_B_COUNT) ||
                       (aw_addr_ff == OFF_IRQ_MASK);
    assign rd_mapped = (araddr == OFF_CTRL) || (araddr == OFF_A_COUNT) ||
                       (araddr == OFF_B_COUNT) ||
                       (araddr == OFF_B_CAPTURE) ||
                       (araddr == OFF_IRQ_STATUS) ||
                       (araddr == OFF_IRQ_MASK);

    assign ctrl_wr = wr_fire && (aw_addr_ff == OFF_CTRL);
    assign a_cnt_wr = wr_fire && (aw_addr_ff == OFF_A_COUNT);
    assign b_cnt_wr = wr_fire && (aw_addr_ff == OFF_B_COUNT);
    assign mask_wr = wr_fire && (aw_addr_ff == OFF_IRQ_MASK);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_ff <= 1'b0;
            aw_addr_ff <= 8'h00;
            w_held_ff <= 1'b0;
            w_data_ff <= 32'h0000_0000;
            w_strb_ff <= 4'h0;
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
        end
        else
        begin
            if (awvalid && !aw_held_ff)
            begin
                aw_held_ff <= 1'b1;
                aw_addr_ff <= awaddr;
            end
            if (wvalid && !w_held_ff)
            begin
                w_held_ff <= 1'b1;
                w_data_ff <= wdata;
                w_strb_ff <= wstrb;
            end
            if (wr_fire)
            begin
                aw_held_ff <= 1'b0;
                w_held_ff <= 1'b0;
                bvalid_ff <= 1'b1;
                bresp_ff <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
            end
            else if (bvalid_ff && bready)
            begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    // -------------------------------------------------------------
    // Control register
    // -------------------------------------------------------------
    always_comb
    begin
        ctrl_rd = 32'h0000_0000;
        ctrl_rd[CTRL_A_START] = a_start_ff;
        ctrl_rd[CTRL_B_START] = b_start_ff;
        ctrl_rd[CTRL_A_MODE_LO +: 2] = a_mode_ff;
        ctrl_rd[CTRL_B_MODE_LO +: 2] = b_mode_ff;
        ctrl_rd[CTRL_B_MSEL] = b_msel_ff;
    end

    assign nxt_ctrl = merge(ctrl_rd, w_data_ff, w_strb_ff);
    assign nxt_a_cnt = merge({16'h0000, a_cnt_ff}, w_data_ff, w_strb_ff);
    assign nxt_b_cnt = merge({16'h0000, b_cnt_ff}, w_data_ff, w_strb_ff);
    assign nxt_mask = merge({30'h0000_0000, mask_ff}, w_data_ff, w_strb_ff);
    assign nxt_a_start = nxt_ctrl[CTRL_A_START];
    assign nxt_b_start = nxt_ctrl[CTRL_B_START];
    assign nxt_a_mode = nxt_ctrl[CTRL_A_MODE_LO +: 2];
    assign nxt_b_msel = nxt_ctrl[CTRL_B_MSEL];

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            a_start_ff <= 1'b0;
            b_start_ff <= 1'b0;
            a_mode_ff <= A_MODE_TIMER;
            b_mode_ff <= B_MODE_TIMER;
            b_msel_ff <= 1'b0;
            a_mode_set_ff <= 1'b0;
        end
        else if (ctrl_wr)
        begin
            a_start_ff <= nxt_a_start;
            b_start_ff <= nxt_b_start;
            a_mode_ff <= nxt_a_mode;
            b_mode_ff <= nxt_ctrl[CTRL_B_MODE_LO +: 2];
            b_msel_ff <= nxt_b_msel;
            a_mode_set_ff <= 1'b1;
        end
    end

    // -------------------------------------------------------------
    // Timer A
    // -------------------------------------------------------------
    assign a_start_rise = ctrl_wr && nxt_a_start && !a_start_ff;
    assign a_stop = ctrl_wr && !nxt_a_start && a_start_ff;
    assign a_os_like = (a_mode_ff == A_MODE_ONESHOT) ||
                       (a_mode_ff == A_MODE_PWM);
    assign a_tick = (a_mode_ff == A_MODE_EVENT) ? a_rise : 1'b1;
    assign a_zero = (a_cnt_ff == 16'h0000);
    // One-shot stays idle after its pulse until restarted
    assign a_run = a_start_ff && a_tick &&
                   !((a_mode_ff == A_MODE_ONESHOT) && a_done_ff);
    assign a_under = a_run && a_zero;

    // Entering one-shot or PWM from timer/event, or first choice after reset
    assign a_mode_evt = ctrl_wr &&
        ((nxt_a_mode == A_MODE_ONESHOT) || (nxt_a_mode == A_MODE_PWM)) &&
        (!a_mode_set_ff || !a_os_like);

    assign a_evt = a_mode_evt ||
        (a_stop && (a_mode_ff == A_MODE_ONESHOT) && !a_done_ff) ||
        (a_stop && (a_mode_ff == A_MODE_PWM) && a_pin_ff) ||
        (!a_stop && a_under &&
         ((a_mode_ff != A_MODE_PWM) || a_pin_ff));

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            a_reload_ff <= CNT_RESET;
        end
        else if (a_cnt_wr)
        begin
            a_reload_ff <= nxt_a_cnt[15:0];
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            a_cnt_ff <= CNT_RESET;
            a_pin_ff <= 1'b0;
            a_done_ff <= 1'b1;
        end
        else if (a_stop)
        begin
            if (a_mode_ff == A_MODE_ONESHOT && !a_done_ff)
            begin
                a_cnt_ff <= a_reload_ff;
                a_pin_ff <= 1'b0;
                a_done_ff <= 1'b1;
            end
            else if (a_mode_ff == A_MODE_PWM)
            begin
                a_pin_ff <= 1'b0;
            end
        end
        else if (a_cnt_wr && !a_start_ff)
        begin
            a_cnt_ff <= nxt_a_cnt[15:0];
        end
        else if (a_start_rise)
        begin
            a_cnt_ff <= a_reload_ff;
            a_pin_ff <= (nxt_a_mode == A_MODE_ONESHOT) ||
                        (nxt_a_mode == A_MODE_PWM);
            a_done_ff <= 1'b0;
        end
        else if (a_under)
        begin
            a_cnt_ff <= a_reload_ff;
            if (a_mode_ff == A_MODE_ONESHOT)
            begin
                a_pin_ff <= 1'b0;
                a_done_ff <= 1'b1;
            end
            else if (a_mode_ff == A_MODE_PWM)
            begin
                a_pin_ff <= ~a_pin_ff;
            end
        end
        else if (a_run)
        begin
            a_cnt_ff <= a_cnt_ff - 16'h0001;
        end
    end

    assign timer_a_output_pin = a_pin_ff;

    // -------------------------------------------------------------
    // Timer B
    // -------------------------------------------------------------
    assign b_start_rise = ctrl_wr && nxt_b_start && !b_start_ff;
    assign b_meas = (b_mode_ff == B_MODE_MEASURE);
    assign b_tick = (b_mode_ff == B_MODE_TIMER) ||
                    ((b_mode_ff == B_MODE_EVENT) && b_rise);
    assign b_zero = (b_cnt_ff == 16'h0000);
    assign b_reload_now = b_start_ff && b_tick && b_zero;
    // Period measures rising to rising; width measures between any edges
    assign b_edge = b_start_ff && b_meas &&
                    (b_rise || (b_msel_ff && b_fall));

    assign b_evt = (b_reload_now && !b_meas) ||
        (b_edge && !b_first_ff) ||
        (ctrl_wr && b_start_ff && b_meas &&
         (nxt_b_msel != b_msel_ff));

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            b_cnt_ff <= CNT_RESET;
            b_reload_ff <= CNT_RESET;
            b_first_ff <= 1'b1;
        end
        else if (b_cnt_wr && !b_start_ff)
        begin
            b_cnt_ff <= nxt_b_cnt[15:0];
            b_reload_ff <= nxt_b_cnt[15:0];
        end
        else if (b_start_rise)
        begin
            b_first_ff <= 1'b1;
            b_cnt_ff <= (nxt_ctrl[CTRL_B_MODE_LO +: 2] == B_MODE_MEASURE) ?
                        CNT_RESET : b_reload_ff;
        end
        else if (b_edge)
        begin
            // First capture holds a partial interval; software discards it
            b_reload_ff <= b_cnt_ff;
            b_cnt_ff <= CNT_RESET;
            b_first_ff <= 1'b0;
        end
        else if (b_start_ff && b_meas)
        begin
            b_cnt_ff <= b_cnt_ff + 16'h0001;
        end
        else if (b_reload_now)
        begin
            b_cnt_ff <= b_reload_ff;
        end
        else if (b_start_ff && b_tick)
        begin
            b_cnt_ff <= b_cnt_ff - 16'h0001;
        end
        else if (b_cnt_wr && !b_meas)
        begin
            b_reload_ff <= nxt_b_cnt[15:0];
        end
    end

    // -------------------------------------------------------------
    // Interrupt status, mask and output
    // -------------------------------------------------------------
    // A new event wins over the clear-on-read of the same cycle
    always_comb
    begin
        nxt_status = status_ff;
        if (rd_fire && araddr == OFF_IRQ_STATUS)
        begin
            nxt_status = 2'h0;
        end
        nxt_status[IRQ_A_BIT] = nxt_status[IRQ_A_BIT] | a_evt;
        nxt_status[IRQ_B_BIT] = nxt_status[IRQ_B_BIT] | b_evt;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            status_ff <= 2'h0;
            mask_ff <= MASK_RESET;
        end
        else
        begin
            status_ff <= nxt_status;
            if (mask_wr)
            begin
                mask_ff <= nxt_mask[1:0];
            end
        end
    end

    assign irq = |(status_ff & mask_ff);

    // -------------------------------------------------------------
    // Read data
    // -------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= RESP_OKAY;
        end
        else if (rd_fire)
        begin
            rvalid_ff <= 1'b1;
            rresp_ff <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
            unique case (araddr)
                OFF_CTRL: rdata_ff <= ctrl_rd;
                OFF_A_COUNT: rdata_ff <= {16'h0000, a_cnt_ff};
                OFF_B_COUNT: rdata_ff <= {16'h0000, (b_reload_now && !b_meas) ?
                                          CNT_RELOAD_READ : b_cnt_ff};
                OFF_B_CAPTURE: rdata_ff <= {16'h0000, b_reload_ff};
                OFF_IRQ_STATUS: rdata_ff <= {30'h0000_0000, status_ff};
                OFF_IRQ_MASK: rdata_ff <= {30'h0000_0000, mask_ff};
                default: rdata_ff <= 32'h0000_0000;
            endcase
        end
        else if (rvalid_ff && rready)
        begin
            rvalid_ff <= 1'b0;
        end
    end
endmodule // tmx_timer_top
`default_nettype wire

// ---- verif/tmx_timer_checker.sv ----
// Port checker for the timer block bus and output pin
`timescale 1ns/1ps
`default_nettype none
module tmx_timer_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic timer_a_output_pin,
    input wire logic irq
);
    import tmx_pkg::*;
    // ---------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------
    logic both_in;
    assign both_in = awvalid && awready && wvalid && wready;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    a_bresp_held: assert property (bvalid && !bready
        |=> bvalid && $stable(bresp))
        else $error("Write response dropped early");
    a_rdata_held: assert property (rvalid && !rready
        |=> rvalid && $stable(rdata))
        else $error("Read data dropped early");
    a_ar_refused: assert property (rvalid |-> !arready)
        else $error("Address taken while read data pending");
    a_read_latency: assert property (arvalid && arready |=> rvalid)
        else $error("Read answer late");
    a_write_latency: assert property (both_in |-> ##2 bvalid)
        else $error("Write answer late");
    a_unmapped_err: assert property (both_in && awaddr > OFF_IRQ_MASK
        |-> ##2 bresp == RESP_SLVERR)
        else $error("Unmapped write not refused");
    // Catches a stop that halts the counter but forgets the pin
    a_stop_pin_low: assert property (
        both_in && awaddr == OFF_CTRL && wstrb[0] && !wdata[CTRL_A_START]
        |-> ##[2:3] !timer_a_output_pin)
        else $error("Pin still high after stop");
    a_reset_quiet: assert property (disable iff (1'b0) !aresetn
        |=> !bvalid && !rvalid && !irq && !timer_a_output_pin)
        else $error("Outputs active after reset");
endmodule // tmx_timer_checker
bind tmx_timer_top tmx_timer_checker i_tmx_timer_checker (.*);
`default_nettype wire

// ---- verif/tmx_timer_top_test.sv ----
// Self-checking bench for the timer block
`timescale 1ns/1ps
`default_nettype none
module tmx_timer_top_test;
    import tmx_pkg::*;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, b_ev;
    logic awready, wready, bvalid, arready, rvalid, pin, irq;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, r, r2;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, lresp;
    int failures, cmp_count, n;
    tmx_timer_top i_tmx_timer_top (.aclk(aclk), .aresetn(aresetn),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .a_event_in(1'b0), .b_event_in(b_ev),
        .timer_a_output_pin(pin), .irq(irq));
    // ---------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_sim;
        $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic hang;
        failures++;
        $display("Error at %0t: wait ran out", $time);
        end_sim;
    endtask
    // Each bus task starts one edge late so no strobe is set twice
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wstrb <= 4'hF;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        lresp = bresp;
        bready <= 1'b0;
        if (n == 50) hang;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        r = rdata;
        lresp = rresp;
        rready <= 1'b0;
        if (n == 50) hang;
    endtask
    function automatic logic [31:0] ca(input logic [1:0] m, input logic s);
        ca = 32'h0000_0000;
        ca[CTRL_A_MODE_LO +: 2] = m;
        ca[CTRL_A_START] = s;
    endfunction
    function automatic logic [31:0] cbv(input logic [1:0] m, input logic s,
        input logic ms);
        cbv = 32'h0000_0000;
        cbv[CTRL_B_MODE_LO +: 2] = m;
        cbv[CTRL_B_START] = s;
        cbv[CTRL_B_MSEL] = ms;
    endfunction
    task automatic do_reset;
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
    endtask
    task automatic pulse;
        @(posedge aclk);
        b_ev <= 1'b1;
        repeat (8) @(posedge aclk);
        b_ev <= 1'b0;
        repeat (8) @(posedge aclk);
    endtask
    // ---------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------
    task automatic t_reset;
        rd(OFF_CTRL);
        chk(r[15:0], 16'h0000);
        rd(OFF_IRQ_MASK);
        chk(r[15:0], 16'(MASK_RESET));
        rd(8'h1C);
        chk(16'(lresp), 16'(RESP_SLVERR));
        wr(8'h18, 32'h0000_0001);
        chk(16'(lresp), 16'(RESP_SLVERR));
        wr(OFF_CTRL, ca(A_MODE_ONESHOT, 1'b0));
        rd(OFF_IRQ_STATUS);
        chk(r[15:0], 16'h0001);
    endtask
    task automatic t_modes;
        logic [1:0] src [2];
        logic [1:0] dst [2];
        src = '{A_MODE_TIMER, A_MODE_EVENT};
        dst = '{A_MODE_ONESHOT, A_MODE_PWM};
        for (int i = 0; i < 4; i++)
        begin
            wr(OFF_CTRL, ca(src[i / 2], 1'b0));
            rd(OFF_IRQ_STATUS);
            wr(OFF_CTRL, ca(dst[i % 2], 1'b0));
            rd(OFF_IRQ_STATUS);
            chk(r[15:0], 16'h0001);
            rd(OFF_IRQ_STATUS);
            chk(r[15:0], 16'h0000);
        end
    endtask
    task automatic t_oneshot;
        wr(OFF_CTRL, ca(A_MODE_ONESHOT, 1'b0));
        wr(OFF_A_COUNT, 32'h0000_0064);
        rd(OFF_IRQ_STATUS);
        wr(OFF_CTRL, ca(A_MODE_ONESHOT, 1'b1));
        chk(16'(pin), 16'h0001);
        rd(OFF_A_COUNT);
        chk(16'(r[15:0] < 16'h0064), 16'h0001);
        wr(OFF_CTRL, ca(A_MODE_ONESHOT, 1'b0));
        chk(16'(pin), 16'h0000);
        rd(OFF_A_COUNT);
        chk(r[15:0], 16'h0064);
        rd(OFF_IRQ_STATUS);
        chk(r[15:0], 16'h0001);
    endtask
    task automatic t_pwm;
        wr(OFF_CTRL, ca(A_MODE_PWM, 1'b0));
        wr(OFF_A_COUNT, 32'h0000_00C8);
        wr(OFF_IRQ_MASK, 32'h0000_0001);
        rd(OFF_IRQ_STATUS);
        wr(OFF_CTRL, ca(A_MODE_PWM, 1'b1));
        chk(16'(pin), 16'h0001);
        wr(OFF_CTRL, ca(A_MODE_PWM, 1'b0));
        chk(16'(pin), 16'h0000);
        chk(16'(irq), 16'h0001);
        wr(OFF_IRQ_MASK, 32'h0000_0002);
        chk(16'(irq), 16'h0000);
        rd(OFF_IRQ_STATUS);
        chk(r[15:0], 16'h0001);
        wr(OFF_CTRL, ca(A_MODE_PWM, 1'b1));
        for (n = 0; n < 600 && pin !== 1'b0; n++) @(posedge aclk);
        if (n == 600) hang;
        rd(OFF_IRQ_STATUS);
        wr(OFF_CTRL, ca(A_MODE_PWM, 1'b0));
        chk(16'(pin), 16'h0000);
        rd(OFF_IRQ_STATUS);
        chk(r[15:0], 16'h0000);
    endtask
    task automatic t_bcount;
        wr(OFF_B_COUNT, 32'h0000_1234);
        rd(OFF_B_COUNT);
        chk(r[15:0], 16'h1234);
        wr(OFF_CTRL, cbv(B_MODE_TIMER, 1'b1, 1'b0));
        rd(OFF_B_COUNT);
        r2 = r;
        rd(OFF_B_COUNT);
        chk(16'(r2[15:0] < 16'h1234), 16'h0001);
        chk(16'(r[15:0] < r2[15:0]), 16'h0001);
        // A zero count reloads every tick, so any read meets the reload
        wr(OFF_CTRL, cbv(B_MODE_TIMER, 1'b0, 1'b0));
        wr(OFF_B_COUNT, 32'h0000_0000);
        wr(OFF_CTRL, cbv(B_MODE_TIMER, 1'b1, 1'b0));
        rd(OFF_B_COUNT);
        chk(r[15:0], CNT_RELOAD_READ);
    endtask
    task automatic t_measure;
        wr(OFF_CTRL, cbv(B_MODE_MEASURE, 1'b1, 1'b0));
        rd(OFF_IRQ_STATUS);
        pulse;
        rd(OFF_IRQ_STATUS);
        chk(r[15:0], 16'h0000);
        pulse;
        rd(OFF_IRQ_STATUS);
        chk(r[15:0], 16'h0002);
        wr(OFF_CTRL, cbv(B_MODE_MEASURE, 1'b1, 1'b1));
        rd(OFF_IRQ_STATUS);
        chk(r[15:0], 16'h0002);
    endtask
    initial
    begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    initial
    begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, b_ev} = '0;
        {awaddr, araddr, wdata, wstrb} = '0;
        failures = 0;
        cmp_count = 0;
        do_reset;
        t_reset;
        t_modes;
        t_oneshot;
        t_pwm;
        t_bcount;
        t_measure;
        do_reset;
        t_reset;
        end_sim;
    end
endmodule // tmx_timer_top_test
`default_nettype wire
